/* File: hdl/eep_device.sv */
// eeprom client front end: start/stop, byte shifting, address decode
`include "eep_params.svh"

module eep_device #(
    parameter logic [3:0] TYPE_CODE = `EEP_TYPE_CODE
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire link
    eep_if.dev bus,
    // hardware address pins
    input wire logic hw_addr_pin_bit0,
    input wire logic hw_addr_pin_bit1,
    input wire logic hw_addr_pin_bit2,
    // array side
    input wire logic write_busy,
    input wire logic [7:0] tx_data,
    output logic tx_req,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [`EEP_ADDR_W-1:0] word_addr,
    output logic [`EEP_PAGE_W-1:0] page_index,
    output logic [`EEP_OFFS_W-1:0] byte_in_page,
    output logic read_op,
    output logic addr_hit,
    output logic write_trigger,
    output logic standby
);

    // ==========================================
    // address compare
    function automatic logic addr_match(
        input logic [7:0] addr_byte,
        input logic [2:0] pins,
        input logic [3:0] code
    );
        logic type_ok;
        logic pins_ok;
        type_ok = addr_byte[`EEP_TYPE_MSB:`EEP_TYPE_LSB] == code;
        pins_ok = addr_byte[`EEP_PIN_MSB:`EEP_PIN_LSB] == pins;
        addr_match = type_ok & pins_ok;
    endfunction : addr_match

    // ==========================================
    // input synchronizers
    logic [4:0] sync_a_reg;
    logic [4:0] sync_b_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_s;
    logic sda_s;
    logic [2:0] pins_s;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_reg <= 5'h1f;
            sync_b_reg <= 5'h1f;
        end else begin
            sync_a_reg <= {bus.scl, bus.sda, hw_addr_pin_bit2, hw_addr_pin_bit1,
                           hw_addr_pin_bit0};
            sync_b_reg <= sync_a_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_s = sync_b_reg[4];
    assign sda_s = sync_b_reg[3];
    assign pins_s = sync_b_reg[2:0];

    // ==========================================
    // edge and condition detect
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ==========================================
    // state
    eep_pkg::eep_phase_t phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_shift_reg;
    logic ack_pending_reg;
    logic dev_tx_reg;
    logic sda_oe_reg;
    logic wrote_reg;
    logic byte_done;
    logic ack_slot_rise;
    logic ack_slot_fall;
    logic hit;
    logic host_nack;

    assign shift_next = {shift_reg[6:0], sda_s};
    assign byte_done = scl_rise & (bit_cnt_reg == `EEP_LAST_DATA_BIT);
    assign ack_slot_rise = scl_rise & (bit_cnt_reg == `EEP_ACK_SLOT);
    assign ack_slot_fall = scl_fall & (bit_cnt_reg == `EEP_ACK_SLOT);
    assign hit = addr_match(shift_next, pins_s, TYPE_CODE) & ~write_busy;
    assign host_nack = ack_slot_rise & dev_tx_reg & sda_s;

    // ==========================================
    // bit counter
    // each scl fall in a transfer counts as a bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 4'h0;
        end else if (start_det) begin
            bit_cnt_reg <= 4'hf;
        end else if (stop_det || phase_reg == eep_pkg::EEP_IDLE) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_fall) begin
            // eight data clocks then ack clock
            if (bit_cnt_reg == `EEP_ACK_SLOT) begin
                bit_cnt_reg <= 4'h0;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // capture on rising scl, msb first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
        end else if (scl_rise && bit_cnt_reg < `EEP_ACK_SLOT) begin
            shift_reg <= shift_next;
        end
    end

    // ==========================================
    // phase control
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= eep_pkg::EEP_IDLE;
        end else if (start_det) begin
            phase_reg <= eep_pkg::EEP_DEVADDR;
        end else if (stop_det) begin
            phase_reg <= eep_pkg::EEP_IDLE;
        end else if (byte_done) begin
            case (phase_reg)
                eep_pkg::EEP_DEVADDR: begin
                    if (!hit) begin
                        phase_reg <= eep_pkg::EEP_IDLE;
                    end else if (shift_next[`EEP_RW_BIT]) begin
                        phase_reg <= eep_pkg::EEP_RDATA;
                    end else begin
                        phase_reg <= eep_pkg::EEP_WA_HI;
                    end
                end
                eep_pkg::EEP_WA_HI: begin
                    phase_reg <= eep_pkg::EEP_WA_LO;
                end
                eep_pkg::EEP_WA_LO: begin
                    phase_reg <= eep_pkg::EEP_WDATA;
                end
                default: begin
                    // data phase holds for any length
                    phase_reg <= phase_reg;
                end
            endcase
        end else if (host_nack) begin
            phase_reg <= eep_pkg::EEP_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_pending_reg <= 1'b0;
        end else if (start_det || stop_det || ack_slot_fall) begin
            ack_pending_reg <= 1'b0;
        end else if (byte_done) begin
            if (phase_reg == eep_pkg::EEP_DEVADDR) begin
                ack_pending_reg <= hit;
            end else begin
                ack_pending_reg <= phase_reg == eep_pkg::EEP_WA_HI
                    || phase_reg == eep_pkg::EEP_WA_LO
                    || phase_reg == eep_pkg::EEP_WDATA;
            end
        end
    end

    // ==========================================
    // transmit path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_tx_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
        end else if (start_det || stop_det || host_nack) begin
            dev_tx_reg <= 1'b0;
        end else if (ack_slot_fall) begin
            dev_tx_reg <= phase_reg == eep_pkg::EEP_RDATA;
            tx_shift_reg <= tx_data;
        end else if (scl_fall && dev_tx_reg) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
    end

    // sda changes only after falling scl
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_reg <= 1'b0;
        end else if (scl_fall && phase_reg != eep_pkg::EEP_IDLE) begin
            if (bit_cnt_reg == `EEP_LAST_DATA_BIT) begin
                // release as sender, pull low as receiver
                sda_oe_reg <= ack_pending_reg;
            end else if (bit_cnt_reg == `EEP_ACK_SLOT) begin
                // ack released, next byte msb driven
                sda_oe_reg <= phase_reg == eep_pkg::EEP_RDATA && !tx_data[7];
            end else begin
                sda_oe_reg <= dev_tx_reg && !tx_shift_reg[6];
            end
        end else if (scl_fall) begin
            sda_oe_reg <= 1'b0;
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe_reg;

    // ==========================================
    // user side results
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            addr_hit <= 1'b0;
            read_op <= 1'b0;
            tx_req <= 1'b0;
        end else begin
            rx_valid <= byte_done && phase_reg == eep_pkg::EEP_WDATA;
            addr_hit <= byte_done && phase_reg == eep_pkg::EEP_DEVADDR && hit;
            tx_req <= (byte_done && phase_reg == eep_pkg::EEP_DEVADDR && hit
                       && shift_next[`EEP_RW_BIT])
                      || (ack_slot_rise && dev_tx_reg && !sda_s);
            if (byte_done) begin
                rx_data <= shift_next;
            end
            if (byte_done && phase_reg == eep_pkg::EEP_DEVADDR && hit) begin
                read_op <= shift_next[`EEP_RW_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            word_addr <= 12'h000;
        end else if (byte_done && phase_reg == eep_pkg::EEP_WA_HI) begin
            word_addr[11:8] <= shift_next[`EEP_WA_HI_MSB:0];
        end else if (byte_done && phase_reg == eep_pkg::EEP_WA_LO) begin
            word_addr[7:0] <= shift_next;
        end
    end

    assign page_index = word_addr[`EEP_ADDR_W-1:`EEP_OFFS_W];
    assign byte_in_page = word_addr[`EEP_OFFS_W-1:0];

    // ==========================================
    // write trigger and standby
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrote_reg <= 1'b0;
            write_trigger <= 1'b0;
        end else begin
            write_trigger <= stop_det && wrote_reg;
            if (start_det || stop_det) begin
                wrote_reg <= 1'b0;
            end else if (byte_done && phase_reg == eep_pkg::EEP_WDATA) begin
                wrote_reg <= 1'b1;
            end
        end
    end

    // standby when idle and no write runs
    assign standby = phase_reg == eep_pkg::EEP_IDLE && !write_busy;

endmodule : eep_device

/* File: hdl/eep_params.svh */
// constants for the two-wire eeprom front end and its host
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

// ==========================================
// timing
`define EEP_CLK_PERIOD_NS 100
`define EEP_SCL_QTR_NS 2500
`define EEP_SCL_QTR_CYC ((`EEP_SCL_QTR_NS + `EEP_CLK_PERIOD_NS - 1) / `EEP_CLK_PERIOD_NS)

// ==========================================
// device address byte
// type code value is arbitrary
`define EEP_TYPE_CODE 4'h5
`define EEP_TYPE_MSB 7
`define EEP_TYPE_LSB 4
`define EEP_PIN_MSB 3
`define EEP_PIN_LSB 1
`define EEP_RW_BIT 0

// ==========================================
// word address and array layout
`define EEP_WA_HI_MSB 3
`define EEP_ADDR_W 12
`define EEP_PAGE_W 7
`define EEP_OFFS_W 5

// ==========================================
// byte framing
`define EEP_LAST_DATA_BIT 4'h7
`define EEP_ACK_SLOT 4'h8
`define EEP_RECOVER_LAST 4'h8

`endif

/* File: hdl/eep_pkg.sv */
// types shared by both ends of the two-wire link
package eep_pkg;

    // ==========================================
    // client phases
    typedef enum logic [2:0] {
        EEP_IDLE,
        EEP_DEVADDR,
        EEP_WA_HI,
        EEP_WA_LO,
        EEP_WDATA,
        EEP_RDATA
    } eep_phase_t;

    // ==========================================
    // host commands and states
    typedef enum logic [2:0] {
        EEP_OP_START,
        EEP_OP_WRITE,
        EEP_OP_READ,
        EEP_OP_STOP,
        EEP_OP_RECOVER
    } eep_op_t;

    typedef enum logic [2:0] {
        EEP_H_IDLE,
        EEP_H_START,
        EEP_H_BYTE,
        EEP_H_STOP,
        EEP_H_RECOVER
    } eep_hstate_t;

endpackage : eep_pkg

/* File: hdl/eep_if.sv */
// two-wire link between host and eeprom client, with wired-and data line
interface eep_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // ==========================================
    // open-drain resolution with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev(
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host(
        output scl,
        input sda,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : eep_if

/* File: hdl/eep_host.sv */
// two-wire host: start, byte, stop and recovery sequencer
`include "eep_params.svh"

module eep_host #(
    parameter int QTR_CYC = `EEP_SCL_QTR_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire link
    eep_if.host bus,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire eep_pkg::eep_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    // response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_acked,
    output logic recover_ok
);

    // ==========================================
    // state
    eep_pkg::eep_hstate_t state_reg;
    logic [15:0] qcnt_reg;
    logic [1:0] quarter_reg;
    logic [3:0] bit_idx_reg;
    logic [8:0] out_reg;
    logic [8:0] in_reg;
    logic scl_reg;
    logic sda_reg;
    logic sda_a_reg;
    logic sda_b_reg;
    logic tick;

    assign cmd_ready = state_reg == eep_pkg::EEP_H_IDLE;
    assign tick = qcnt_reg == 16'(QTR_CYC - 1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sda_a_reg <= 1'b1;
            sda_b_reg <= 1'b1;
        end else begin
            sda_a_reg <= bus.sda;
            sda_b_reg <= sda_a_reg;
        end
    end

    // ==========================================
    // quarter-period divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qcnt_reg <= 16'h0000;
        end else if (state_reg == eep_pkg::EEP_H_IDLE || tick) begin
            qcnt_reg <= 16'h0000;
        end else begin
            qcnt_reg <= qcnt_reg + 16'h0001;
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= eep_pkg::EEP_H_IDLE;
            quarter_reg <= 2'h0;
            bit_idx_reg <= 4'h0;
            out_reg <= 9'h1ff;
            in_reg <= 9'h000;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_acked <= 1'b0;
            recover_ok <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == eep_pkg::EEP_H_IDLE) begin
                quarter_reg <= 2'h0;
                bit_idx_reg <= 4'h0;
                if (cmd_valid) begin
                    case (cmd_op)
                        eep_pkg::EEP_OP_START: state_reg <= eep_pkg::EEP_H_START;
                        eep_pkg::EEP_OP_STOP: state_reg <= eep_pkg::EEP_H_STOP;
                        eep_pkg::EEP_OP_RECOVER: state_reg <= eep_pkg::EEP_H_RECOVER;
                        default: state_reg <= eep_pkg::EEP_H_BYTE;
                    endcase
                    // write shifts out cmd_data then releases sda for the ack; read releases sda and answers with cmd_nack
                    out_reg <= cmd_op == eep_pkg::EEP_OP_WRITE ? {cmd_data, 1'b1}
                                                              : {8'hff, cmd_nack};
                end
            end else if (tick) begin
                quarter_reg <= quarter_reg + 2'h1;
                case (state_reg)
                    eep_pkg::EEP_H_START: begin
                        case (quarter_reg)
                            2'h0: sda_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= 1'b0;
                            default: begin
                                scl_reg <= 1'b0;
                                state_reg <= eep_pkg::EEP_H_IDLE;
                            end
                        endcase
                    end
                    eep_pkg::EEP_H_STOP: begin
                        case (quarter_reg)
                            2'h0: sda_reg <= 1'b0;
                            2'h1: scl_reg <= 1'b1;
                            default: begin
                                sda_reg <= 1'b1;
                                state_reg <= eep_pkg::EEP_H_IDLE;
                            end
                        endcase
                    end
                    eep_pkg::EEP_H_BYTE: begin
                        case (quarter_reg)
                            2'h0: begin
                                sda_reg <= out_reg[8];
                                out_reg <= {out_reg[7:0], 1'b1};
                            end
                            2'h1: scl_reg <= 1'b1;
                            2'h2: in_reg <= {in_reg[7:0], sda_b_reg};
                            default: begin
                                scl_reg <= 1'b0;
                                bit_idx_reg <= bit_idx_reg + 4'h1;
                                if (bit_idx_reg == `EEP_ACK_SLOT) begin
                                    sda_reg <= 1'b1;
                                    rsp_valid <= 1'b1;
                                    rsp_data <= in_reg[8:1];
                                    rsp_acked <= !in_reg[0];
                                    state_reg <= eep_pkg::EEP_H_IDLE;
                                end
                            end
                        endcase
                    end
                    default: begin
                        // clock until sda high, nine at most
                        case (quarter_reg)
                            2'h0: sda_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: begin
                                if (sda_b_reg) begin
                                    rsp_valid <= 1'b1;
                                    recover_ok <= 1'b1;
                                    state_reg <= eep_pkg::EEP_H_IDLE;
                                end
                            end
                            default: begin
                                scl_reg <= 1'b0;
                                bit_idx_reg <= bit_idx_reg + 4'h1;
                                if (bit_idx_reg == `EEP_RECOVER_LAST) begin
                                    rsp_valid <= 1'b1;
                                    recover_ok <= 1'b0;
                                    state_reg <= eep_pkg::EEP_H_IDLE;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign bus.scl = scl_reg;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = !sda_reg;

endmodule : eep_host

/* File: bench/eep_link_props.sv */
// checker for the two-wire link between host and eeprom front end
module eep_link_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ==========================================
    // start, stop and held acknowledge
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence s_ack_hold;
        dev_sda_oe [*7];
    endsequence
    // ==========================================
    // assertions
    a_dev_high_hold: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device sda moved while scl high");
    a_dev_late_move: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
        else $error("device sda moved too soon after scl fall");
    a_ack_full_high: assert property ($rose(scl) && dev_sda_oe |-> s_ack_hold)
        else $error("device low level not held over scl high");
    a_no_fight_high: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
        else $error("both ends drive sda while scl high");
    a_start_by_host: assert property (s_start |-> host_sda_oe && !dev_sda_oe)
        else $error("start not made by host alone");
    a_stop_release: assert property (s_stop |-> !dev_sda_oe [*4])
        else $error("device drives sda after stop");
    a_scl_high_span: assert property ($rose(scl) |-> scl [*6])
        else $error("scl high phase too short");
    a_host_edge_hold: assert property (scl && $past(scl) && $changed(host_sda_oe) |-> scl [*3])
        else $error("host sda change while scl high not framed");
endmodule : eep_link_props

/* File: bench/eeprom_i2c_client_front_end_tb.sv */
// testbench: host and eeprom front end joined over the two-wire link
`include "eep_params.svh"
module eeprom_i2c_client_front_end_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] TC = `EEP_TYPE_CODE;
    localparam eep_pkg::eep_op_t ST = eep_pkg::EEP_OP_START;
    localparam eep_pkg::eep_op_t WR = eep_pkg::EEP_OP_WRITE;
    localparam eep_pkg::eep_op_t RD = eep_pkg::EEP_OP_READ;
    localparam eep_pkg::eep_op_t SP = eep_pkg::EEP_OP_STOP;
    localparam eep_pkg::eep_op_t RC = eep_pkg::EEP_OP_RECOVER;
    logic clock = 0;
    logic rst_n = 0;
    logic [2:0] pins = 0;
    logic write_busy = 0;
    logic [7:0] tx_data = 0;
    logic cmd_valid = 0;
    eep_pkg::eep_op_t cmd_op = ST;
    logic [7:0] cmd_data = 0;
    logic cmd_nack = 0;
    logic cmd_ready, rsp_valid, rsp_acked, recover_ok, rx_valid, read_op, write_trigger, standby;
    logic tx_req, addr_hit;
    logic [7:0] rsp_data, rx_data;
    logic [`EEP_ADDR_W-1:0] word_addr;
    logic [`EEP_PAGE_W-1:0] page_index;
    logic [`EEP_OFFS_W-1:0] byte_in_page;
    int failures = 0;
    int total_checks = 0;
    int trig_cnt = 0;
    int rx_cnt = 0;
    int hit_cnt = 0;
    int req_cnt = 0;
    // ==========================================
    // design, link and checker
    eep_if eep_if_inst ();
    eep_host #(.QTR_CYC(4)) eep_host_inst (.clock(clock), .rst_n(rst_n), .bus(eep_if_inst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_acked(rsp_acked), .recover_ok(recover_ok));
    eep_device eep_device_inst (.clock(clock), .rst_n(rst_n), .bus(eep_if_inst),
        .hw_addr_pin_bit0(pins[0]), .hw_addr_pin_bit1(pins[1]), .hw_addr_pin_bit2(pins[2]),
        .write_busy(write_busy), .tx_data(tx_data), .tx_req(tx_req), .rx_data(rx_data),
        .rx_valid(rx_valid), .word_addr(word_addr), .page_index(page_index),
        .byte_in_page(byte_in_page), .read_op(read_op), .addr_hit(addr_hit),
        .write_trigger(write_trigger), .standby(standby));
    eep_link_props eep_link_props_inst (.clock(clock), .rst_n(rst_n), .scl(eep_if_inst.scl),
        .sda(eep_if_inst.sda), .host_sda_oe(eep_if_inst.host_sda_oe),
        .dev_sda_oe(eep_if_inst.dev_sda_oe));
    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (write_trigger === 1'h1) trig_cnt++;
        if (rx_valid === 1'h1) rx_cnt++;
        if (addr_hit === 1'h1) hit_cnt++;
        if (tx_req === 1'h1) req_cnt++;
    end
    // ==========================================
    // tasks and expectations
    function automatic logic exp_ack(input logic [7:0] a, input logic [2:0] p, input logic b);
        return a[7:4] == TC && a[3:1] == p && !b;
    endfunction : exp_ack
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(input eep_pkg::eep_op_t op, input logic [7:0] d, input logic nk);
        int n;
        n = 0;
        @(negedge clock);
        while (cmd_ready !== 1'h1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        cmd_op = op;
        cmd_data = d;
        cmd_nack = nk;
        cmd_valid = 1;
        @(negedge clock);
        cmd_valid = 0;
        while (op != ST && op != SP && rsp_valid !== 1'h1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 3000) failures++;
    endtask : cmd
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        #3_000_000;
        failures++;
        stop_test();
    end
    // ==========================================
    // tests
    initial begin
        logic [7:0] hi, lo, a, d;
        void'($urandom(51));
        pins = 3'($urandom);
        tx_data = 8'($urandom);
        repeat (10) @(negedge clock);
        rst_n = 1;
        repeat (6) @(negedge clock);
        hi = 8'($urandom);
        lo = 8'($urandom);
        cmd(ST, 8'h00, 1'h0);
        cmd(WR, {TC, pins, 1'h0}, 1'h0);
        chk("addr ack", 12'h001, rsp_acked);
        cmd(WR, hi, 1'h0);
        chk("hi ack", 12'h001, rsp_acked);
        cmd(WR, lo, 1'h0);
        chk("word_addr", {hi[3:0], lo}, word_addr);
        chk("page_index", {hi[3:0], lo[7:5]}, page_index);
        chk("byte_in_page", lo[4:0], byte_in_page);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            cmd(WR, d, 1'h0);
            chk("rx_data", d, rx_data);
        end
        chk("rx count", 12'h003, 12'(rx_cnt));
        cmd(SP, 8'h00, 1'h0);
        $display("test write done");
        cmd(ST, 8'h00, 1'h0);
        cmd(WR, {TC, pins, 1'h1}, 1'h0);
        chk("trigger", 12'h001, 12'(trig_cnt));
        chk("read_op", 12'h001, read_op);
        cmd(RD, 8'h00, 1'h0);
        chk("read byte", tx_data, rsp_data);
        cmd(RD, 8'h00, 1'h1);
        chk("read last", tx_data, rsp_data);
        chk("standby", 12'h001, standby);
        chk("sda free", 12'h001, eep_if_inst.sda);
        cmd(ST, 8'h00, 1'h0);
        cmd(WR, {TC, pins, 1'h1}, 1'h0);
        chk("restart ack", 12'h001, rsp_acked);
        tx_data = 8'h00;
        cmd(RD, 8'h00, 1'h0);
        cmd(RC, 8'h00, 1'h0);
        chk("recover", 12'h001, recover_ok);
        chk("addr hits", 12'h003, 12'(hit_cnt));
        chk("tx requests", 12'h004, 12'(req_cnt));
        $display("test read done");
        for (int i = 0; i < 9; i++) begin
            pins = 3'($urandom);
            write_busy = (i == 8);
            a = {TC, pins, 1'h0};
            if (i < 4) a[4+i] = ~a[4+i];
            else if (i < 7) a[i-3] = ~a[i-3];
            else if (i == 7) a = {7'($urandom), 1'h0};
            cmd(ST, 8'h00, 1'h0);
            cmd(WR, a, 1'h0);
            chk("addr ack", exp_ack(a, pins, write_busy), rsp_acked);
            cmd(WR, 8'($urandom), 1'h0);
            chk("ignored", 12'h000, rsp_acked & ~exp_ack(a, pins, write_busy));
            cmd(SP, 8'h00, 1'h0);
        end
        write_busy = 0;
        $display("test address done");
        stop_test();
    end
endmodule : eeprom_i2c_client_front_end_tb
